// ---- rrsd_decoder.sv ----
// Remote recipe select decoder: input decode, hold timing, command, relay.
`timescale 1ns/1ps
module rrsd_decoder #(
    parameter int HOLD_CYCLES  = rrsd_pkg::HOLD_CYCLES,
    parameter int RELAY_CYCLES = rrsd_pkg::RELAY_CYCLES,
    parameter int BAUD_DIV     = rrsd_pkg::BAUD_DIV,
    parameter int CNT_W        = rrsd_pkg::CNT_W
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic [rrsd_pkg::SEL_W-1:0] sel_in,
    input  wire logic                      method_a,
    input  wire logic                      method_b,
    output logic                           txd,
    output logic                           selection_done_relay
);

    localparam int SW = rrsd_pkg::SEL_W;
    localparam int RW = rrsd_pkg::RECIPE_W;

    // Returns {valid, recipe}; used for both capture and hold checking.
    function automatic logic [RW:0] rrsd_decode(
        input logic [1:0]    method,
        input logic [SW-1:0] sel
    );
        logic [3:0]    hits;
        logic [RW-1:0] idx;
        logic [3:0]    tens;
        logic [3:0]    units;
        logic [RW-1:0] bcd_val;
        logic          ok;
        logic [RW-1:0] num;
        hits    = 4'h0;
        idx     = '0;
        tens    = sel[7:4];
        units   = sel[3:0];
        bcd_val = RW'({3'h0, tens} * rrsd_pkg::BCD_TENS_MUL)
                + RW'({3'h0, units});
        ok      = 1'b0;
        num     = '0;
        unique case (method)
            rrsd_pkg::METHOD_DISCRETE: begin
                for (int i = 0; i < rrsd_pkg::DISCRETE_MAX; i++) begin
                    if (sel[i]) begin
                        hits = hits + 4'h1;
                        idx  = RW'(i + 1);
                    end
                end
                ok  = (hits == 4'h1);
                num = idx;
            end
            rrsd_pkg::METHOD_BCD: begin
                ok  = (tens <= rrsd_pkg::BCD_DIGIT_MAX) &&
                      (units <= rrsd_pkg::BCD_DIGIT_MAX) &&
                      (bcd_val != '0);
                num = bcd_val;
            end
            rrsd_pkg::METHOD_BINARY: begin
                num = sel[RW-1:0];
                ok  = (num != '0) && (num <= rrsd_pkg::RECIPE_MAX);
            end
            rrsd_pkg::METHOD_UNUSED: begin
                ok  = 1'b0;
                num = '0;
            end
        endcase
        return {ok, num};
    endfunction

    // Plant pins are asynchronous to ref_clk and pass two flops first.
    logic [SW+1:0] meta_r;
    logic [SW+1:0] sync_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {method_b, method_a, sel_in};
            sync_r <= meta_r;
        end
    end

    logic [1:0]    method_s;
    logic [SW-1:0] sel_s;
    logic [RW:0]   dec;
    logic          is_zero;

    assign method_s = sync_r[SW+1:SW];
    assign sel_s    = sync_r[SW-1:0];
    assign dec      = rrsd_decode(method_s, sel_s);
    assign is_zero  = (sel_s == '0);

    rrsd_pkg::rrsd_state_t state_r;
    rrsd_pkg::rrsd_state_t state_nxt;
    logic [SW+1:0]         code_r;
    logic [SW+1:0]         code_nxt;
    logic [RW-1:0]         recipe_r;
    logic [RW-1:0]         recipe_nxt;
    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cnt_nxt;
    logic                  byte_idx_r;
    logic                  byte_idx_nxt;
    logic                  launched_r;
    logic                  launched_nxt;
    logic                  relay_r;
    logic                  relay_nxt;
    logic                  tx_start;
    logic [7:0]            tx_data;
    logic                  tx_ready;
    logic                  tx_done;

    assign tx_data = byte_idx_r ? {1'b0, recipe_r} : rrsd_pkg::CMD_HEADER;
    assign selection_done_relay = relay_r;

    always_comb begin
        state_nxt    = state_r;
        code_nxt     = code_r;
        recipe_nxt   = recipe_r;
        cnt_nxt      = cnt_r;
        byte_idx_nxt = byte_idx_r;
        launched_nxt = launched_r;
        relay_nxt    = relay_r;
        tx_start     = 1'b0;
        unique case (state_r)
            rrsd_pkg::ST_WAIT_ZERO: begin
                if (is_zero) begin
                    state_nxt = rrsd_pkg::ST_IDLE;
                end
            end
            rrsd_pkg::ST_IDLE: begin
                if (!is_zero) begin
                    code_nxt   = sync_r;
                    recipe_nxt = dec[RW-1:0];
                    cnt_nxt    = '0;
                    state_nxt  = rrsd_pkg::ST_HOLD;
                end
            end
            rrsd_pkg::ST_HOLD: begin
                // Bits may settle one by one, so any change restarts timing.
                if (is_zero) begin
                    state_nxt = rrsd_pkg::ST_IDLE;
                end else if (sync_r != code_r) begin
                    code_nxt   = sync_r;
                    recipe_nxt = dec[RW-1:0];
                    cnt_nxt    = '0;
                end else if (dec[RW]) begin
                    if (cnt_r == CNT_W'(HOLD_CYCLES)) begin
                        state_nxt = rrsd_pkg::ST_HELD;
                    end else begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
            end
            rrsd_pkg::ST_HELD: begin
                if (is_zero) begin
                    byte_idx_nxt = 1'b0;
                    launched_nxt = 1'b0;
                    state_nxt    = rrsd_pkg::ST_SEND;
                end else if (sync_r != code_r) begin
                    // A different code without a zero in between is void.
                    state_nxt = rrsd_pkg::ST_WAIT_ZERO;
                end
            end
            rrsd_pkg::ST_SEND: begin
                if (!launched_r && tx_ready) begin
                    tx_start     = 1'b1;
                    launched_nxt = 1'b1;
                end
                if (tx_done) begin
                    if (byte_idx_r) begin
                        relay_nxt = 1'b1;
                        cnt_nxt   = '0;
                        state_nxt = rrsd_pkg::ST_RELAY;
                    end else begin
                        byte_idx_nxt = 1'b1;
                        launched_nxt = 1'b0;
                    end
                end
            end
            rrsd_pkg::ST_RELAY: begin
                // Pulse length suits a controller start input if wired so.
                if (cnt_r == CNT_W'(RELAY_CYCLES - 1)) begin
                    relay_nxt = 1'b0;
                    state_nxt = rrsd_pkg::ST_WAIT_ZERO;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            default: begin
                state_nxt = rrsd_pkg::ST_WAIT_ZERO;
                relay_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r    <= rrsd_pkg::ST_WAIT_ZERO;
            code_r     <= '0;
            recipe_r   <= '0;
            cnt_r      <= '0;
            byte_idx_r <= 1'b0;
            launched_r <= 1'b0;
            relay_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            code_r     <= code_nxt;
            recipe_r   <= recipe_nxt;
            cnt_r      <= cnt_nxt;
            byte_idx_r <= byte_idx_nxt;
            launched_r <= launched_nxt;
            relay_r    <= relay_nxt;
        end
    end

    rrsd_uart_tx #(
        .BAUD_DIV (BAUD_DIV),
        .DIV_W    (rrsd_pkg::DIV_W)
    ) u_tx (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tx_start (tx_start),
        .tx_data  (tx_data),
        .tx_ready (tx_ready),
        .tx_done  (tx_done),
        .txd      (txd)
    );

endmodule

// ---- rrsd_pkg.sv ----
// Shared constants and types for the remote recipe select decoder.
package rrsd_pkg;

    localparam int CLK_KHZ      = 50_000;
    localparam int HOLD_MS      = 200;
    localparam int HOLD_CYCLES  = HOLD_MS * CLK_KHZ;
    localparam int RELAY_MS     = 200;
    localparam int RELAY_CYCLES = RELAY_MS * CLK_KHZ;
    localparam int BAUD_RATE    = 9600;
    localparam int BAUD_DIV     = (CLK_KHZ * 1000) / BAUD_RATE;
    localparam int CNT_W        = 24;
    localparam int DIV_W        = 16;

    localparam int SEL_W        = 10;
    localparam int RECIPE_W     = 7;
    localparam int DISCRETE_MAX = 10;

    localparam logic [6:0] RECIPE_MAX    = 7'h63;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [6:0] BCD_TENS_MUL  = 7'h0a;

    localparam logic [1:0] METHOD_DISCRETE = 2'h0;
    localparam logic [1:0] METHOD_BCD      = 2'h1;
    localparam logic [1:0] METHOD_BINARY   = 2'h2;
    localparam logic [1:0] METHOD_UNUSED   = 2'h3;

    localparam logic [7:0] CMD_HEADER = 8'h52;
    localparam logic [2:0] LAST_BIT   = 3'h7;

    typedef enum logic [2:0] {
        ST_WAIT_ZERO = 3'h0,
        ST_IDLE      = 3'h1,
        ST_HOLD      = 3'h3,
        ST_HELD      = 3'h2,
        ST_SEND      = 3'h6,
        ST_RELAY     = 3'h7
    } rrsd_state_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'h0,
        TX_START = 2'h1,
        TX_DATA  = 2'h3,
        TX_STOP  = 2'h2
    } rrsd_tx_state_t;

endpackage

// ---- rrsd_uart_tx.sv ----
// Serial 8N1 byte transmitter for the recipe command link.
`timescale 1ns/1ps
module rrsd_uart_tx #(
    parameter int BAUD_DIV = rrsd_pkg::BAUD_DIV,
    parameter int DIV_W    = rrsd_pkg::DIV_W
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            tx_done,
    output logic            txd
);

    rrsd_pkg::rrsd_tx_state_t state_r;
    rrsd_pkg::rrsd_tx_state_t state_nxt;
    logic [DIV_W-1:0]         div_r;
    logic [DIV_W-1:0]         div_nxt;
    logic [2:0]               bit_r;
    logic [2:0]               bit_nxt;
    logic [7:0]               shift_r;
    logic [7:0]               shift_nxt;
    logic                     txd_r;
    logic                     txd_nxt;
    logic                     done_r;
    logic                     done_nxt;
    logic                     tick;

    assign tick     = (div_r == DIV_W'(BAUD_DIV - 1));
    assign tx_ready = (state_r == rrsd_pkg::TX_IDLE);
    assign tx_done  = done_r;
    assign txd      = txd_r;

    always_comb begin
        state_nxt = state_r;
        div_nxt   = tick ? '0 : div_r + DIV_W'(1);
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        txd_nxt   = txd_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            rrsd_pkg::TX_IDLE: begin
                div_nxt = '0;
                txd_nxt = 1'b1;
                if (tx_start) begin
                    shift_nxt = tx_data;
                    txd_nxt   = 1'b0;
                    state_nxt = rrsd_pkg::TX_START;
                end
            end
            rrsd_pkg::TX_START: begin
                if (tick) begin
                    txd_nxt   = shift_r[0];
                    shift_nxt = {1'b0, shift_r[7:1]};
                    bit_nxt   = 3'h0;
                    state_nxt = rrsd_pkg::TX_DATA;
                end
            end
            rrsd_pkg::TX_DATA: begin
                if (tick) begin
                    if (bit_r == rrsd_pkg::LAST_BIT) begin
                        txd_nxt   = 1'b1;
                        state_nxt = rrsd_pkg::TX_STOP;
                    end else begin
                        txd_nxt   = shift_r[0];
                        shift_nxt = {1'b0, shift_r[7:1]};
                        bit_nxt   = bit_r + 3'h1;
                    end
                end
            end
            rrsd_pkg::TX_STOP: begin
                if (tick) begin
                    done_nxt  = 1'b1;
                    state_nxt = rrsd_pkg::TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= rrsd_pkg::TX_IDLE;
            div_r   <= '0;
            bit_r   <= 3'h0;
            shift_r <= 8'h00;
            txd_r   <= 1'b1;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            div_r   <= div_nxt;
            bit_r   <= bit_nxt;
            shift_r <= shift_nxt;
            txd_r   <= txd_nxt;
            done_r  <= done_nxt;
        end
    end

endmodule

// ---- rrsd_decoder_asserts.sv ----
// Port-level timing checks for the recipe select decoder.
`timescale 1ns/1ps
module rrsd_decoder_asserts #(
    parameter int HOLD_CYCLES  = rrsd_pkg::HOLD_CYCLES,
    parameter int RELAY_CYCLES = rrsd_pkg::RELAY_CYCLES,
    parameter int BAUD_DIV     = rrsd_pkg::BAUD_DIV
) (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic [rrsd_pkg::SEL_W-1:0] sel_in,
    input wire logic                       method_a,
    input wire logic                       method_b,
    input wire logic                       txd,
    input wire logic                       selection_done_relay
);
    localparam int HALF  = BAUD_DIV / 2;
    localparam int QUIET = 7 * BAUD_DIV;
    localparam int STOPM = 9 * BAUD_DIV + HALF;
    logic [15:0] quiet_r;
    logic [15:0] quiet_nxt;
    logic [23:0] on_r;
    logic [23:0] on_nxt;
    logic        hdr;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // A header follows an idle spell longer than any run of ones inside a
    // frame: six data bits of a recipe byte, or the gap between two bytes.
    assign hdr = !txd && (quiet_r > QUIET);

    always_comb begin
        quiet_nxt = (quiet_r == 16'hffff) ? quiet_r : quiet_r + 16'h0001;
        quiet_nxt = txd ? quiet_nxt : 16'h0000;
        on_nxt    = selection_done_relay ? on_r + 24'h00_0001 : 24'h00_0000;
    end

    always_ff @(posedge ref_clk) begin
        quiet_r <= rst_n ? quiet_nxt : 16'h0000;
        on_r    <= rst_n ? on_nxt : 24'h00_0000;
    end

    sequence s_hdr_bits;
        ##HALF !txd ##BAUD_DIV !txd ##BAUD_DIV txd ##BAUD_DIV !txd;
    endsequence

    property p_reset_out;
        $rose(rst_n) |-> txd && !selection_done_relay;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not idle after reset");
    property p_hdr_after_zero;
        hdr |-> $past(sel_in, 3) == '0;
    endproperty
    a_hdr_after_zero: assert property (p_hdr_after_zero)
        else $error("command started while inputs not zero");
    property p_hdr_bits;
        hdr |-> s_hdr_bits;
    endproperty
    a_hdr_bits: assert property (p_hdr_bits)
        else $error("header bits or bit time wrong");
    property p_hdr_stop;
        hdr |-> ##STOPM txd;
    endproperty
    a_hdr_stop: assert property (p_hdr_stop)
        else $error("header stop bit missing");
    property p_relay_after_stop;
        $rose(selection_done_relay) |-> $past(txd, 1) && $past(txd, BAUD_DIV);
    endproperty
    a_relay_after_stop: assert property (p_relay_after_stop)
        else $error("relay closed before the stop bit ended");
    property p_relay_idle;
        selection_done_relay |-> txd;
    endproperty
    a_relay_idle: assert property (p_relay_idle)
        else $error("serial line busy during relay pulse");
    property p_relay_len;
        $fell(selection_done_relay) |-> on_r == RELAY_CYCLES;
    endproperty
    a_relay_len: assert property (p_relay_len)
        else $error("relay pulse length wrong");
    property p_quiet_after;
        $fell(selection_done_relay) |-> txd [*8];
    endproperty
    a_quiet_after: assert property (p_quiet_after)
        else $error("command sent straight after relay pulse");
endmodule

// ---- rrsd_mix_model.sv ----
// Behavioural mix controller that receives serial recipe commands.
`timescale 1ns/1ps
module rrsd_mix_model #(
    parameter int BAUD_DIV    = 4,
    parameter int NUM_RECIPES = 99
) (
    input wire logic   ref_clk,
    input wire logic   txd,
    input wire logic   selection_done_relay,
    input wire logic   at_menu,
    output int         cmd_count,
    output logic [7:0] recipe,
    output int         start_count
);
    logic [7:0] rx_byte;
    bit         got_hdr;

    initial begin
        cmd_count   = 0;
        start_count = 0;
        recipe      = 8'h00;
        got_hdr     = 0;
    end

    // Samples each bit in its middle; a bad stop bit drops the frame.
    always begin
        @(negedge txd);
        repeat (BAUD_DIV / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BAUD_DIV) @(posedge ref_clk);
            rx_byte[i] = txd;
        end
        repeat (BAUD_DIV) @(posedge ref_clk);
        if (txd !== 1'b1) begin
            got_hdr = 0;
        end else if (!got_hdr) begin
            got_hdr = (rx_byte === rrsd_pkg::CMD_HEADER);
        end else begin
            got_hdr = 0;
            cmd_count++;
            if (at_menu && rx_byte >= 1 &&
                rx_byte <= NUM_RECIPES) begin
                recipe = rx_byte;
            end
        end
    end

    always @(posedge selection_done_relay) begin
        start_count++;
    end
endmodule

// ---- test_rrsd_decoder.sv ----
// Self-checking bench for the remote recipe select decoder.
`timescale 1ns/1ps
module test_rrsd_decoder;
    localparam int HOLD = 20;
    localparam int BDIV = 4;
    logic                       ref_clk;
    logic                       rst_n;
    logic [rrsd_pkg::SEL_W-1:0] sel_in;
    logic                       method_a;
    logic                       method_b;
    logic                       txd;
    logic                       selection_done_relay;
    logic [7:0]                 recipe;
    int                         bad_count;
    int                         num_checks;
    int                         cycles;
    int                         cmd_count;
    int                         start_count;
    int                         hold_len;

    rrsd_decoder #(.HOLD_CYCLES(HOLD), .RELAY_CYCLES(10), .BAUD_DIV(BDIV),
        .CNT_W(24)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .sel_in(sel_in),
        .method_a(method_a), .method_b(method_b), .txd(txd),
        .selection_done_relay(selection_done_relay));
    rrsd_mix_model #(.BAUD_DIV(BDIV), .NUM_RECIPES(99)) ctrl (
        .ref_clk(ref_clk), .txd(txd), .at_menu(1'b1),
        .selection_done_relay(selection_done_relay), .cmd_count(cmd_count),
        .recipe(recipe), .start_count(start_count));

    task automatic close_out();
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // Presents a code for hold_len cycles, returns to zero, waits it out.
    task automatic send(input logic [1:0] ba, input logic [9:0] code,
                        input logic [7:0] exp, input int more);
        int c0;
        int s0;
        int n;
        c0 = cmd_count;
        s0 = start_count;
        n = 0;
        @(negedge ref_clk);
        {method_b, method_a} = ba;
        sel_in = code;
        repeat (hold_len) @(negedge ref_clk);
        sel_in = '0;
        while (!selection_done_relay && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        while (selection_done_relay) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        check(cmd_count == c0 + more, "command count");
        check(start_count == s0 + more, "relay pulse count");
        check(recipe === exp, "recipe number");
    endtask

    task automatic t_codes();
        send(2'h1, 10'h099, 8'h63, 1);
        send(2'h1, 10'h345, 8'h2d, 1);
        send(2'h2, 10'h063, 8'h63, 1);
        send(2'h2, 10'h381, 8'h01, 1);
        for (int n = 1; n <= 10; n++) begin
            send(2'h0, 10'h001 << (n - 1), 8'(n), 1);
        end
    endtask

    // Every refused case must leave the last good recipe in place.
    task automatic t_refuse();
        send(2'h3, 10'h012, recipe, 0);
        send(2'h1, 10'h01a, recipe, 0);
        send(2'h1, 10'h0a1, recipe, 0);
        send(2'h1, 10'h300, recipe, 0);
        send(2'h2, 10'h064, recipe, 0);
        send(2'h0, 10'h003, recipe, 0);
        hold_len = HOLD;
        send(2'h1, 10'h012, recipe, 0);
        hold_len = HOLD + 3;
        send(2'h1, 10'h012, 8'h0c, 1);
        hold_len = HOLD + 8;
    endtask

    // A code change mid-hold restarts timing; two held codes with no zero between give no command.
    task automatic t_rearm();
        int c0;
        c0 = cmd_count;
        @(negedge ref_clk);
        sel_in = 10'h015;
        repeat (HOLD - 5) @(negedge ref_clk);
        sel_in = 10'h016;
        repeat (HOLD - 5) @(negedge ref_clk);
        sel_in = '0;
        repeat (200) @(negedge ref_clk);
        check(cmd_count == c0, "restart of hold timing");
        sel_in = 10'h021;
        repeat (HOLD + 8) @(negedge ref_clk);
        sel_in = 10'h022;
        repeat (HOLD + 8) @(negedge ref_clk);
        sel_in = '0;
        repeat (300) @(negedge ref_clk);
        check(cmd_count == c0, "changed held code not void");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        rst_n = 1'b0;
        sel_in = '0;
        method_a = 1'b0;
        method_b = 1'b0;
        hold_len = HOLD + 8;
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        t_codes();
        t_refuse();
        t_rearm();
        close_out();
    end
endmodule

bind rrsd_decoder rrsd_decoder_asserts #(.HOLD_CYCLES(HOLD_CYCLES),
    .RELAY_CYCLES(RELAY_CYCLES), .BAUD_DIV(BAUD_DIV)) chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .sel_in(sel_in), .method_a(method_a),
    .method_b(method_b), .txd(txd),
    .selection_done_relay(selection_done_relay));
